// >>> dv/rdms_term_model.sv
// rdms_term_model: switch bank driving the input terminals and the keypad run key
// assumes: bench requests change just after rising mclk edges
`timescale 1ns/1ps
`default_nettype none
module rdms_term_model (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [5:0] sw_req,
  input  wire logic       key_req,
  output logic      [5:0] term_in,
  output logic            keypad_run_key
);
  // ==========================================================
  // contacts settle one edge after a request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      term_in        <= 6'h00; // unpowered terminals read no voltage
      keypad_run_key <= 1'h0;
    end else begin
      term_in        <= sw_req; // every terminal follows its request bit
      keypad_run_key <= key_req;
    end
  end
endmodule // rdms_term_model
`default_nettype wire

// >>> dv/rdms_top_tb.sv
// rdms_top_tb: self-checking bench for run, direction and speed decode
// assumes: rdms_top with default parameters, switch model on the terminals
`timescale 1ns/1ps
`default_nettype none
module rdms_top_tb;
  typedef struct packed {
    logic [5:0] sw;
    logic [2:0] rfr;
    logic [3:0] idx;
  } rdms_row_t;
  logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic        key_req, keypad_run_key, run_active, dir_forward, dir_reverse;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  sw_req, term_in;
  logic [3:0]  speed_index;
  logic [15:0] target_freq;
  int          err_total, n_compared;
  rdms_row_t   rows [11] = '{'{6'h00, 3'h0, 4'h0}, '{6'h01, 3'h6, 4'h0}, '{6'h02, 3'h5, 4'h0},
    '{6'h03, 3'h0, 4'h0}, '{6'h04, 3'h0, 4'h1}, '{6'h08, 3'h0, 4'h2}, '{6'h10, 3'h0, 4'h4},
    '{6'h20, 3'h0, 4'h8}, '{6'h3c, 3'h0, 4'hf}, '{6'h29, 3'h6, 4'ha}, '{6'h37, 3'h0, 4'hd}};
  logic [7:0]  ra [4] = '{rdms_pkg::ADDR_TFUNC0, rdms_pkg::ADDR_TFUNC1, rdms_pkg::ADDR_MAXF,
    rdms_pkg::ADDR_BASE};
  logic [31:0] rst_val [4] = '{rdms_pkg::RST_TFUNC0, rdms_pkg::RST_TFUNC1, 32'h0000_ffff,
    32'h0};

  // ==========================================================
  // design and switch model
  rdms_top rdms_top_inst (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .term_in(term_in), .keypad_run_key(keypad_run_key),
    .run_active(run_active), .dir_forward(dir_forward), .dir_reverse(dir_reverse),
    .speed_index(speed_index), .target_freq(target_freq));
  rdms_term_model rdms_term_model_inst (.mclk(mclk), .arst_n(arst_n), .sw_req(sw_req),
    .key_req(key_req), .term_in(term_in), .keypad_run_key(keypad_run_key));

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask

  task automatic exp_out(input logic [5:0] sw, input logic [2:0] rfr, input logic [3:0] idx,
                         input logic [15:0] tg);
    sw_req <= sw;
    repeat (6) @(posedge mclk);
    chk({29'h0, run_active, dir_forward, dir_reverse}, {29'h0, rfr});
    chk({28'h0, speed_index}, {28'h0, idx});
    chk({16'h0, target_freq}, {16'h0, tg});
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, tests
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    results;
  end

  initial begin
    arst_n = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
    pwdata = 32'h0; sw_req = 6'h00; key_req = 1'h0; err_total = 0; n_compared = 0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'h1;
    @(posedge mclk);
    apb(1'h1, rdms_pkg::ADDR_BASE, 32'h0000_0123);
    for (int i = 1; i < 16; i++) begin
      apb(1'h1, rdms_pkg::ADDR_EDIT, {12'h000, i[3:0], 16'h1000 + i[15:0]});
      apb(1'h1, rdms_pkg::ADDR_SETKEY, 32'h1);
    end
    foreach (rows[k]) exp_out(rows[k].sw, rows[k].rfr, rows[k].idx, (rows[k].idx == 4'h0) ?
      16'h0123 : 16'h1000 + 16'(rows[k].idx));
    // select functions moved to other terminals
    apb(1'h1, rdms_pkg::ADDR_TFUNC0, 32'h0204_0105);
    apb(1'h1, rdms_pkg::ADDR_TFUNC1, 32'h0000_0003);
    exp_out(6'h21, 3'h6, 4'h8, 16'h1008);
    exp_out(6'h18, 3'h0, 4'h3, 16'h1003);
    // normally closed forward terminal
    apb(1'h1, rdms_pkg::ADDR_NC, 32'h20);
    exp_out(6'h00, 3'h6, 4'h0, 16'h0123);
    exp_out(6'h20, 3'h0, 4'h0, 16'h0123);
    apb(1'h1, rdms_pkg::ADDR_NC, 32'h0);
    // keypad run key routing
    key_req <= 1'h1;
    exp_out(6'h00, 3'h6, 4'h0, 16'h0123);
    apb(1'h1, rdms_pkg::ADDR_ROUTE, 32'h1);
    exp_out(6'h00, 3'h5, 4'h0, 16'h0123);
    exp_out(6'h20, 3'h6, 4'h0, 16'h0123);
    key_req <= 1'h0;
    // edit held until set key
    apb(1'h1, rdms_pkg::ADDR_EDIT, 32'h0001_beef);
    exp_out(6'h08, 3'h0, 4'h1, 16'h1001);
    apb(1'h1, rdms_pkg::ADDR_SETKEY, 32'h1);
    exp_out(6'h08, 3'h0, 4'h1, 16'hbeef);
    // commit above the limit refused
    apb(1'h1, rdms_pkg::ADDR_MAXF, 32'h0100);
    apb(1'h1, rdms_pkg::ADDR_EDIT, 32'h0001_0200);
    apb(1'h1, rdms_pkg::ADDR_SETKEY, 32'h1);
    exp_out(6'h08, 3'h0, 4'h1, 16'hbeef);
    apb(1'h0, rdms_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[8]}, 32'h1);
    // error flag cleared by writing one, then a speed zero commit
    apb(1'h1, rdms_pkg::ADDR_STATUS, 32'h0000_0100);
    apb(1'h0, rdms_pkg::ADDR_STATUS, 32'h0);
    chk({31'h0, rd[8]}, 32'h0);
    apb(1'h1, rdms_pkg::ADDR_EDIT, 32'h0000_00a5);
    apb(1'h1, rdms_pkg::ADDR_SETKEY, 32'h1);
    exp_out(6'h00, 3'h0, 4'h0, 16'h00a5);
    // unmapped address
    apb(1'h0, 8'h40, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // reset while stopped
    arst_n <= 1'h0;
    @(posedge mclk);
    chk({9'h0, run_active, dir_forward, dir_reverse, speed_index, target_freq}, 32'h0);
    arst_n <= 1'h1;
    @(posedge mclk);
    foreach (ra[k]) begin
      apb(1'h0, ra[k], 32'h0);
      chk(rd, rst_val[k]);
    end
    results;
  end
endmodule // rdms_top_tb
`default_nettype wire

// >>> hdl/rdms_pkg.sv
// rdms_pkg: constants for the run direction and multispeed select block
// assumes: APB byte addresses on an 8-bit paddr, 32-bit data
package rdms_pkg;
  // ===========================================================
  // sizes
  localparam int unsigned N_TERM    = 6;
  localparam int unsigned SPEED_N   = 16;
  localparam int unsigned SEL_W     = 4;
  localparam int unsigned FREQ_W    = 16;
  localparam int unsigned OPT_W     = 8;

  // ===========================================================
  // terminal function option codes
  localparam logic [7:0] OPT_FWD    = 8'h00;
  localparam logic [7:0] OPT_REV    = 8'h01;
  localparam logic [7:0] OPT_SEL0   = 8'h02;
  localparam logic [7:0] OPT_SEL1   = 8'h03;
  localparam logic [7:0] OPT_SEL2   = 8'h04;
  localparam logic [7:0] OPT_SEL3   = 8'h05;

  // ===========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_TFUNC0 = 8'h00;
  localparam logic [7:0] ADDR_TFUNC1 = 8'h04;
  localparam logic [7:0] ADDR_NC     = 8'h08;
  localparam logic [7:0] ADDR_ROUTE  = 8'h0c;
  localparam logic [7:0] ADDR_BASE   = 8'h10;
  localparam logic [7:0] ADDR_MAXF   = 8'h14;
  localparam logic [7:0] ADDR_EDIT   = 8'h18;
  localparam logic [7:0] ADDR_SETKEY = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // ===========================================================
  // field positions
  localparam int unsigned ST_RUN_BIT   = 0;
  localparam int unsigned ST_FWD_BIT   = 1;
  localparam int unsigned ST_REV_BIT   = 2;
  localparam int unsigned ST_IDX_LSB   = 4;
  localparam int unsigned ST_ERR_BIT   = 8;
  localparam int unsigned ST_FREQ_LSB  = 16;
  localparam int unsigned EDIT_IDX_LSB = 16;
  localparam int unsigned SETKEY_BIT   = 0;
  localparam int unsigned TERMS_PER_W  = 4;

  // ===========================================================
  // reset values
  localparam logic [31:0] RST_TFUNC0 = 32'h0302_0100;
  localparam logic [31:0] RST_TFUNC1 = 32'h0000_0504;
  localparam logic        RST_ROUTE  = 1'b0;
  localparam logic [15:0] RST_BASE   = 16'h0000;
  localparam logic [15:0] RST_MAXF   = 16'hffff;
endpackage

// >>> hdl/rdms_sel_if.sv
// rdms_sel_if: raw and synchronised terminal levels between top and synchroniser
// assumes: one clock domain, mclk
`timescale 1ns/1ps
`default_nettype none
interface rdms_sel_if #(
  parameter int unsigned N_TERM = rdms_pkg::N_TERM
);
  logic [N_TERM-1:0] raw;
  logic [N_TERM-1:0] sync;
  modport src (input raw, output sync);
  modport dst (output raw, input sync);
endinterface // rdms_sel_if
`default_nettype wire

// >>> hdl/rdms_term_sync.sv
// rdms_term_sync: two-flop synchroniser for the intelligent input terminals
// assumes: raw levels come from switches, sync is read on mclk
`timescale 1ns/1ps
`default_nettype none
module rdms_term_sync #(
  parameter int unsigned N_TERM = rdms_pkg::N_TERM
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  rdms_sel_if.src   sel
);
  typedef struct packed {
    logic [N_TERM-1:0] meta;
    logic [N_TERM-1:0] sync;
  } rdms_sync_state_t;

  rdms_sync_state_t state_ff;
  rdms_sync_state_t nxt_state;

  // ===========================================================
  // two stages
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = sel.raw;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign sel.sync = state_ff.sync;

  // ===========================================================
  // checks
  a_sync_delay: assert property (@(posedge mclk) disable iff (!arst_n)
    $past(arst_n) && $past(arst_n, 2) |-> sel.sync == $past(sel.raw, 2))
    else $error("terminal sync delay is not two cycles");
endmodule // rdms_term_sync
`default_nettype wire

// >>> hdl/rdms_top.sv
// rdms_top: run/stop, direction and multispeed decode of input terminals, APB slave
// assumes: APB master on mclk, terminal levels asynchronous switches
`timescale 1ns/1ps
`default_nettype none
// Operation
// - forward input alone: run forward, else stop
// - reverse input alone: run reverse, else stop
// - both inputs on: stop, no direction
// - normally closed terminal open means asserted
// - keypad routing picks keypad run direction only
// - sixteen stored speeds chosen by four inputs
// - first select is bit 0, fourth bit 3
// - any select function on any terminal
// - codes 03, 04, 05 map bits 1-3
// - index zero uses base frequency source
// - target follows select inputs in real time
// - entry stored only on set key press
module rdms_top #(
  parameter int unsigned N_TERM = rdms_pkg::N_TERM,
  parameter int unsigned FREQ_W = rdms_pkg::FREQ_W
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [N_TERM-1:0] term_in,
  input  wire logic              keypad_run_key,
  output logic                   run_active,
  output logic                   dir_forward,
  output logic                   dir_reverse,
  output logic [3:0]             speed_index,
  output logic [FREQ_W-1:0]      target_freq
);
  typedef struct packed {
    logic [N_TERM-1:0][7:0]                  tfunc;
    logic [N_TERM-1:0]                       nc;
    logic                                    route;
    logic [FREQ_W-1:0]                       base;
    logic [FREQ_W-1:0]                       maxf;
    logic [3:0]                              edit_idx;
    logic [FREQ_W-1:0]                       edit_val;
    logic [rdms_pkg::SPEED_N-1:0][FREQ_W-1:0] tbl;
    logic                                    err;
    logic                                    run;
    logic                                    fwd;
    logic                                    rev;
    logic [3:0]                              idx;
    logic [FREQ_W-1:0]                       freq;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
  } rdms_state_t;

  rdms_state_t       state_ff;
  rdms_state_t       nxt_state;
  logic [N_TERM-1:0] act_c;
  logic              fwd_c;
  logic              rev_c;
  logic [3:0]        idx_c;
  logic              acc_c;
  logic              wr_c;
  logic              set_wr_c;
  logic              hit_c;
  logic [31:0]       rd_c;
  logic [63:0]       fvec_c;

  rdms_sel_if #(.N_TERM(N_TERM)) sel ();

  assign sel.raw = term_in;

  rdms_term_sync #(.N_TERM(N_TERM)) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .sel    (sel)
  );

  // ===========================================================
  // terminal decode
  always_comb begin
    nxt_state = state_ff;
    act_c     = sel.sync ^ state_ff.nc;
    fwd_c     = 1'b0;
    rev_c     = 1'b0;
    idx_c     = 4'h0;
    for (int k = 0; k < N_TERM; k++) begin
      if (act_c[k]) begin
        unique case (state_ff.tfunc[k])
          rdms_pkg::OPT_FWD:  fwd_c    = 1'b1;
          rdms_pkg::OPT_REV:  rev_c    = 1'b1;
          rdms_pkg::OPT_SEL0: idx_c[0] = 1'b1;
          rdms_pkg::OPT_SEL1: idx_c[1] = 1'b1;
          rdms_pkg::OPT_SEL2: idx_c[2] = 1'b1;
          rdms_pkg::OPT_SEL3: idx_c[3] = 1'b1;
          default: ;
        endcase
      end
    end

    // run state and direction
    if (fwd_c && rev_c) begin
      nxt_state.run = 1'b0;
      nxt_state.fwd = 1'b0;
      nxt_state.rev = 1'b0;
    end else if (fwd_c) begin
      nxt_state.run = 1'b1;
      nxt_state.fwd = 1'b1;
      nxt_state.rev = 1'b0;
    end else if (rev_c) begin
      nxt_state.run = 1'b1;
      nxt_state.fwd = 1'b0;
      nxt_state.rev = 1'b1;
    end else if (keypad_run_key) begin
      nxt_state.run = 1'b1;
      nxt_state.fwd = !state_ff.route;
      nxt_state.rev = state_ff.route;
    end else begin
      nxt_state.run = 1'b0;
      nxt_state.fwd = 1'b0;
      nxt_state.rev = 1'b0;
    end

    // speed index and target, updated every cycle
    nxt_state.idx = idx_c;
    if (idx_c == 4'h0) begin
      nxt_state.freq = state_ff.base;
    end else begin
      nxt_state.freq = state_ff.tbl[idx_c];
    end

    // ===========================================================
    // apb slave, one wait state
    acc_c    = psel && penable && !state_ff.pready;
    wr_c     = psel && penable && state_ff.pready && pwrite;
    set_wr_c = wr_c && (paddr == rdms_pkg::ADDR_SETKEY) && pwdata[rdms_pkg::SETKEY_BIT];
    fvec_c   = 64'h0;
    for (int k = 0; k < N_TERM; k++) begin
      fvec_c[8*k +: 8] = state_ff.tfunc[k];
    end
    hit_c = 1'b1;
    rd_c  = 32'h0;
    unique case (paddr)
      rdms_pkg::ADDR_TFUNC0: rd_c = fvec_c[31:0];
      rdms_pkg::ADDR_TFUNC1: rd_c = fvec_c[63:32];
      rdms_pkg::ADDR_NC:     rd_c[N_TERM-1:0] = state_ff.nc;
      rdms_pkg::ADDR_ROUTE:  rd_c[0] = state_ff.route;
      rdms_pkg::ADDR_BASE:   rd_c[FREQ_W-1:0] = state_ff.base;
      rdms_pkg::ADDR_MAXF:   rd_c[FREQ_W-1:0] = state_ff.maxf;
      rdms_pkg::ADDR_EDIT: begin
        rd_c[FREQ_W-1:0] = state_ff.edit_val;
        rd_c[rdms_pkg::EDIT_IDX_LSB +: 4] = state_ff.edit_idx;
      end
      rdms_pkg::ADDR_SETKEY: rd_c = 32'h0;
      rdms_pkg::ADDR_STATUS: begin
        rd_c[rdms_pkg::ST_RUN_BIT] = state_ff.run;
        rd_c[rdms_pkg::ST_FWD_BIT] = state_ff.fwd;
        rd_c[rdms_pkg::ST_REV_BIT] = state_ff.rev;
        rd_c[rdms_pkg::ST_IDX_LSB +: 4] = state_ff.idx;
        rd_c[rdms_pkg::ST_ERR_BIT] = state_ff.err;
        rd_c[rdms_pkg::ST_FREQ_LSB +: FREQ_W] = state_ff.freq;
      end
      default: hit_c = 1'b0;
    endcase
    nxt_state.pready  = acc_c;
    nxt_state.pslverr = acc_c && !hit_c;
    nxt_state.prdata  = (acc_c && !pwrite) ? rd_c : 32'h0;

    // register writes at the completing edge
    if (wr_c) begin
      unique case (paddr)
        rdms_pkg::ADDR_TFUNC0, rdms_pkg::ADDR_TFUNC1: begin
          for (int k = 0; k < N_TERM; k++) begin
            if ((k < rdms_pkg::TERMS_PER_W) == (paddr == rdms_pkg::ADDR_TFUNC0)) begin
              nxt_state.tfunc[k] = pwdata[8*(k % rdms_pkg::TERMS_PER_W) +: 8];
            end
          end
        end
        rdms_pkg::ADDR_NC:    nxt_state.nc    = pwdata[N_TERM-1:0];
        rdms_pkg::ADDR_ROUTE: nxt_state.route = pwdata[0];
        rdms_pkg::ADDR_BASE:  nxt_state.base  = pwdata[FREQ_W-1:0];
        rdms_pkg::ADDR_MAXF:  nxt_state.maxf  = pwdata[FREQ_W-1:0];
        rdms_pkg::ADDR_EDIT: begin
          nxt_state.edit_val = pwdata[FREQ_W-1:0];
          nxt_state.edit_idx = pwdata[rdms_pkg::EDIT_IDX_LSB +: 4];
        end
        rdms_pkg::ADDR_STATUS: begin
          if (pwdata[rdms_pkg::ST_ERR_BIT]) begin
            nxt_state.err = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // set key commit, refused above the maximum limit; set wins over clear
    if (set_wr_c) begin
      if (state_ff.edit_val > state_ff.maxf) begin
        nxt_state.err = 1'b1;
      end else if (state_ff.edit_idx == 4'h0) begin
        nxt_state.base = state_ff.edit_val;
      end else begin
        nxt_state.tbl[state_ff.edit_idx] = state_ff.edit_val;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff       <= '0;
      state_ff.route <= rdms_pkg::RST_ROUTE;
      state_ff.base  <= rdms_pkg::RST_BASE[FREQ_W-1:0];
      state_ff.maxf  <= rdms_pkg::RST_MAXF[FREQ_W-1:0];
      for (int k = 0; k < N_TERM; k++) begin
        if (k < rdms_pkg::TERMS_PER_W) begin
          state_ff.tfunc[k] <= rdms_pkg::RST_TFUNC0[8*k +: 8];
        end else begin
          state_ff.tfunc[k] <= rdms_pkg::RST_TFUNC1[8*(k % rdms_pkg::TERMS_PER_W) +: 8];
        end
      end
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ===========================================================
  // outputs
  assign prdata      = state_ff.prdata;
  assign pready      = state_ff.pready;
  assign pslverr     = state_ff.pslverr;
  assign run_active  = state_ff.run;
  assign dir_forward = state_ff.fwd;
  assign dir_reverse = state_ff.rev;
  assign speed_index = state_ff.idx;
  assign target_freq = state_ff.freq;

  // ===========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_both_stop: assert property (fwd_c && rev_c
    |=> !run_active && !dir_forward && !dir_reverse)
    else $error("both run inputs did not stop");
  a_fwd_run: assert property (fwd_c && !rev_c
    |=> run_active && dir_forward && !dir_reverse)
    else $error("forward input did not run forward");
  a_rev_run: assert property (rev_c && !fwd_c
    |=> run_active && dir_reverse && !dir_forward)
    else $error("reverse input did not run reverse");
  a_idle_stop: assert property (!fwd_c && !rev_c && !keypad_run_key |=> !run_active)
    else $error("no run command but running");
  a_stop_nodir: assert property (!run_active |-> !dir_forward && !dir_reverse)
    else $error("direction shown in stop state");
  a_dir_excl: assert property (!(dir_forward && dir_reverse))
    else $error("both directions driven");
  a_keypad_route: assert property (!fwd_c && !rev_c && keypad_run_key
    |=> run_active && dir_reverse == $past(state_ff.route))
    else $error("keypad run direction wrong");
  a_keypad_fwd: assert property (!fwd_c && !rev_c && keypad_run_key && !state_ff.route
    |=> dir_forward && !dir_reverse)
    else $error("keypad run not forward by default routing");
  a_route_term: assert property (fwd_c && !rev_c && state_ff.route |=> dir_forward)
    else $error("keypad routing changed terminal decode");
  a_nc_open: assert property ((state_ff.nc[0] && !sel.sync[0]
    && state_ff.tfunc[0] == rdms_pkg::OPT_FWD) |-> fwd_c)
    else $error("open normally closed terminal not asserted");
  a_sel_lsb: assert property (act_c[2]
    && state_ff.tfunc[2] == rdms_pkg::OPT_SEL0 |=> speed_index[0])
    else $error("first select input not index bit 0");
  a_sel_msb: assert property (act_c[N_TERM-1]
    && state_ff.tfunc[N_TERM-1] == rdms_pkg::OPT_SEL3 |=> speed_index[3])
    else $error("fourth select input not index bit 3");
  a_idx_follow: assert property ($changed(idx_c) |=> speed_index == $past(idx_c)
    && (speed_index == 4'h0 || target_freq == $past(state_ff.tbl[idx_c])))
    else $error("speed index did not follow inputs");
  a_speed0_base: assert property (idx_c == 4'h0
    |=> target_freq == $past(state_ff.base))
    else $error("speed zero not from base source");
  a_commit_only: assert property ($changed(state_ff.tbl) |-> $past(set_wr_c))
    else $error("table changed without set key");

  // ===========================================================
  // apb and commit checks
  a_apb_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("error response without ready");
  a_rd_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_over_limit: assert property (set_wr_c && state_ff.edit_val > state_ff.maxf
    |=> state_ff.err && $stable(state_ff.tbl) && $stable(state_ff.base))
    else $error("commit above limit was stored");
  a_base_commit: assert property (set_wr_c && state_ff.edit_idx == 4'h0
    && state_ff.edit_val <= state_ff.maxf |=> state_ff.base == $past(state_ff.edit_val))
    else $error("speed zero commit did not reach base");

  c_fwd_run: cover property (fwd_c && !rev_c ##1 run_active);
  c_both_on: cover property (fwd_c && rev_c ##1 !run_active);
  c_commit: cover property (set_wr_c ##1 !state_ff.err);
  c_speed15: cover property (speed_index == 4'hf);
  c_keypad_rev: cover property (keypad_run_key && !fwd_c && !rev_c ##1 dir_reverse);
endmodule // rdms_top
`default_nettype wire
